// >>> ssi_core.sv
/*
  Two-wire serial port core: master and slave byte engine, APB registers,
  interrupt gathering. Assumes open-drain SCL/SDA resolved outside and a
  single 250 MHz clock; pin inputs are asynchronous.
*/
// Added by the designer: register access over APB.
// Functional notes
// - Whole bytes, most significant bit first
// - Full byte goes to buffer, raises flag
// - Buffer write loads buffer and shifter together
// - Shifter is hidden from software
// - Address register: own address or rate reload
// - Mask shares address slot, mask mode only
// - Controls read/write except the hardware-owned acknowledge bit; status upper two writable
// - Master waits while clock held low
// - Master watches data line for arbitration
// - Status bit 7 sample point in SPI
// - Status bit 7 disables slew control
// - Status bit 6 transmit edge in SPI
// - Status bit 6 enables bus-specific levels
// - Status bit 5 data versus address
// - Status bit 4 stop seen last
`timescale 1ns/1ns
`default_nettype none

module ssi_core (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  // Bus pins, open drain
  input  wire logic        i_scl,
  output var  logic        o_scl,
  output var  logic        o_scl_oe_n,
  input  wire logic        i_sda,
  output var  logic        o_sda,
  output var  logic        o_sda_oe_n,
  // Pad controls and interrupt
  output var  logic        o_slew_ctrl_off,
  output var  logic        o_smbus_levels,
  output var  logic        o_irq
);

  // Pin synchronisers and edge history
  logic scl_meta_q, scl_q, scl_prev_q;
  logic sda_meta_q, sda_q, sda_prev_q;

  // Registers seen by software
  ssi_pkg::ssi_stat_type stat_q, stat_d;
  logic [7:0]             ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, ctrl3_q, ctrl3_d;
  logic [7:0]             buf_q, buf_d, own_q, own_d, mask_q, mask_d;
  logic [ssi_pkg::IRQ_W-1:0] irq_q, irq_d, irq_en_q, irq_en_d;
  logic [31:0]            rdata_q, rdata_d;

  // Engine state
  ssi_pkg::ssi_mst_type  m_st_q, m_st_d;
  ssi_pkg::ssi_slv_type  s_st_q, s_st_d;
  logic [7:0]             shf_q, shf_d;        // bit_shifter, loaded by buffer writes, no read path
  logic [3:0]             cnt_q, cnt_d;        // Clock slot within byte
  logic [6:0]             brg_q, brg_d;        // Rate divider
  logic                   scl_low_q, scl_low_d, sda_low_q, sda_low_d;
  logic                   rw_q, rw_d, ack_q, ack_d, tx_q, tx_d;

  // Engine events toward the register group
  logic byte_ev, load_buf, is_data, arb_ev, start_done, stop_done, rcv_done;

  // Decode
  logic       wr_en, rd_acc, setup, hit, buf_wr, tick, match;
  logic       master_mode, slave_mode, mask_mode;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic [9:0] idx;

  // Two flops before any logic looks at a pin
  always_ff @(posedge i_clk)
  begin
    scl_meta_q <= i_scl;
    scl_q      <= scl_meta_q;
    scl_prev_q <= scl_q;
    sda_meta_q <= i_sda;
    sda_q      <= sda_meta_q;
    sda_prev_q <= sda_q;
  end

  // Bus conditions from the settled copies
  assign scl_rise  = scl_q & ~scl_prev_q;
  assign scl_fall  = ~scl_q & scl_prev_q;
  assign start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_det  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

  // Access decode; zero wait states, so every access phase completes
  assign idx       = i_paddr[11:2];
  assign setup     = i_psel & ~i_penable;
  assign wr_en     = i_psel & i_penable & i_pwrite & hit;
  assign rd_acc    = i_psel & i_penable & ~i_pwrite & hit;
  assign buf_wr    = wr_en & (idx == ssi_pkg::IDX_BUFFER);
  assign hit       = (idx >= ssi_pkg::IDX_STATUS) && (idx <= ssi_pkg::IDX_IRQ_EN);

  // Mode selection
  assign master_mode = ctrl1_q[ssi_pkg::CTRL1_EN_BIT] & (ctrl1_q[3:0] == ssi_pkg::MODE_MASTER);
  assign mask_mode   = ctrl1_q[3:0] == ssi_pkg::MODE_MASK;
  assign slave_mode  = ctrl1_q[ssi_pkg::CTRL1_EN_BIT] &
                       ((ctrl1_q[3:0] == ssi_pkg::MODE_SLAVE7) | mask_mode);

  // Masked compare of the received address against our own
  assign match = (((shf_q[7:1] ^ own_q[7:1]) & mask_q[7:1]) == 7'h00);
  assign tick  = (brg_q == 7'h00);

  // Engine: next state for master and slave sequencers
  always_comb
  begin
    m_st_d     = m_st_q;
    s_st_d     = s_st_q;
    shf_d      = shf_q;
    cnt_d      = cnt_q;
    scl_low_d  = scl_low_q;
    sda_low_d  = sda_low_q;
    rw_d       = rw_q;
    ack_d      = ack_q;
    tx_d       = tx_q;
    byte_ev    = 1'b0;
    load_buf   = 1'b0;
    is_data    = 1'b0;
    arb_ev     = 1'b0;
    start_done = 1'b0;
    stop_done  = 1'b0;
    rcv_done   = 1'b0;
    // Divider reloads from the low seven address bits in master mode
    brg_d = (tick | ~master_mode) ? own_q[6:0] : brg_q - 7'h01;
    // A buffer write also lands in the shifter, no second stage
    if (buf_wr)
      shf_d = i_pwdata[7:0];
    if (master_mode)
    begin
      s_st_d = ssi_pkg::S_IDLE;
      case (m_st_q)
        ssi_pkg::M_IDLE:
          if (ctrl2_q[ssi_pkg::CTRL2_START] && tick)
          begin
            sda_low_d = 1'b1;
            m_st_d    = ssi_pkg::M_START;
          end
        ssi_pkg::M_START:
          if (tick)
          begin
            scl_low_d  = 1'b1;
            start_done = 1'b1;
            m_st_d     = ssi_pkg::M_HOLD;
          end
        // Bus owned, clock held low, waiting for software
        ssi_pkg::M_HOLD:
          if (buf_wr)
          begin
            tx_d   = 1'b1;
            cnt_d  = 4'h0;
            m_st_d = ssi_pkg::M_LOW;
          end
          else if (ctrl2_q[ssi_pkg::CTRL2_RCV])
          begin
            tx_d     = 1'b0;
            cnt_d    = 4'h0;
            rcv_done = 1'b1;
            m_st_d   = ssi_pkg::M_LOW;
          end
          else if (ctrl2_q[ssi_pkg::CTRL2_STOP] && tick)
          begin
            sda_low_d = 1'b1;
            m_st_d    = ssi_pkg::M_STOP;
          end
        // Present the next bit while the clock is low
        ssi_pkg::M_LOW:
          if (tick)
          begin
            if (cnt_q != ssi_pkg::SLOT_ACK)
              sda_low_d = tx_q & ~shf_q[7];
            else
              sda_low_d = ~tx_q & ~ctrl2_q[ssi_pkg::CTRL2_ACKDT];
            m_st_d = ssi_pkg::M_REL;
          end
        ssi_pkg::M_REL:
          if (tick)
          begin
            scl_low_d = 1'b0;
            m_st_d    = ssi_pkg::M_RISE;
          end
        // Clock released; a slave holding it low keeps us here
        ssi_pkg::M_RISE:
          if (scl_q)
            m_st_d = ssi_pkg::M_HIGH;
        ssi_pkg::M_HIGH:
          if (tick)
          begin
            if (!sda_low_q && !sda_q && tx_q && cnt_q != ssi_pkg::SLOT_ACK)
            begin
              // Another master pulled a one to zero: back off entirely
              arb_ev    = 1'b1;
              scl_low_d = 1'b0;
              sda_low_d = 1'b0;
              m_st_d    = ssi_pkg::M_IDLE;
            end
            else
            begin
              scl_low_d = 1'b1;
              cnt_d     = cnt_q + 4'h1;
              if (cnt_q != ssi_pkg::SLOT_ACK)
              begin
                shf_d = {shf_q[6:0], sda_q};
                m_st_d = ssi_pkg::M_LOW;
              end
              else
              begin
                ack_d    = sda_q;
                byte_ev  = 1'b1;
                load_buf = ~tx_q;
                m_st_d   = ssi_pkg::M_HOLD;
              end
            end
          end
        ssi_pkg::M_STOP:
          if (tick)
          begin
            scl_low_d = 1'b0;
            m_st_d    = ssi_pkg::M_STOPW;
          end
        ssi_pkg::M_STOPW:
          if (tick && scl_q)
          begin
            sda_low_d = 1'b0;
            stop_done = 1'b1;
            m_st_d    = ssi_pkg::M_IDLE;
          end
        default:
          m_st_d = ssi_pkg::M_IDLE;
      endcase
    end
    else if (slave_mode)
    begin
      m_st_d = ssi_pkg::M_IDLE;
      if (start_det)
      begin
        s_st_d    = ssi_pkg::S_ADDR;
        cnt_d     = 4'h0;
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
      else if (stop_det)
      begin
        s_st_d    = ssi_pkg::S_IDLE;
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
      else if (s_st_q == ssi_pkg::S_TX && scl_low_q && buf_wr)
      begin
        // Software refilled the buffer: drive the top bit, free the clock
        sda_low_d = ~i_pwdata[7];
        scl_low_d = 1'b0;
      end
      else if (scl_rise && s_st_q != ssi_pkg::S_IDLE)
      begin
        cnt_d = cnt_q + 4'h1;
        if (s_st_q != ssi_pkg::S_TX && cnt_q != ssi_pkg::SLOT_ACK)
          shf_d = {shf_q[6:0], sda_q};
        else if (s_st_q == ssi_pkg::S_TX && cnt_q == ssi_pkg::SLOT_ACK)
          ack_d = sda_q;
      end
      else if (scl_fall && s_st_q != ssi_pkg::S_IDLE)
      begin
        if (cnt_q == ssi_pkg::SLOT_ACK)
        begin
          byte_ev = 1'b1;
          case (s_st_q)
            ssi_pkg::S_ADDR:
              if (match)
              begin
                sda_low_d = 1'b1;
                load_buf  = 1'b1;
                rw_d      = shf_q[0];
              end
              else
              begin
                byte_ev = 1'b0;
                s_st_d  = ssi_pkg::S_IDLE;
              end
            ssi_pkg::S_RX:
            begin
              sda_low_d = 1'b1;
              load_buf  = 1'b1;
              is_data   = 1'b1;
            end
            default:
            begin
              sda_low_d = 1'b0;
              is_data   = 1'b1;
            end
          endcase
        end
        else if (cnt_q == ssi_pkg::SLOT_END)
        begin
          cnt_d     = 4'h0;
          sda_low_d = 1'b0;
          if (s_st_q == ssi_pkg::S_ADDR)
            s_st_d = rw_q ? ssi_pkg::S_TX : ssi_pkg::S_RX;
          // Holding the clock until software supplies the next byte
          scl_low_d = (s_st_q == ssi_pkg::S_ADDR && rw_q) ||
                      (s_st_q == ssi_pkg::S_TX && !ack_q);
          if (s_st_q == ssi_pkg::S_TX && ack_q)
            s_st_d = ssi_pkg::S_IDLE;
        end
        else if (s_st_q == ssi_pkg::S_TX)
        begin
          sda_low_d = ~shf_q[6];
          shf_d     = {shf_q[6:0], 1'b0};
        end
      end
    end
    else
    begin
      // Port off: release both lines and park
      m_st_d    = ssi_pkg::M_IDLE;
      s_st_d    = ssi_pkg::S_IDLE;
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
    end
  end

  // Engine registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      m_st_q    <= ssi_pkg::M_IDLE;
      s_st_q    <= ssi_pkg::S_IDLE;
      shf_q     <= 8'h00;
      cnt_q     <= 4'h0;
      brg_q     <= 7'h00;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      rw_q      <= 1'b0;
      ack_q     <= 1'b0;
      tx_q      <= 1'b0;
    end
    else
    begin
      m_st_q    <= m_st_d;
      s_st_q    <= s_st_d;
      shf_q     <= shf_d;
      cnt_q     <= cnt_d;
      brg_q     <= brg_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      rw_q      <= rw_d;
      ack_q     <= ack_d;
      tx_q      <= tx_d;
    end
  end

  // Register file: software writes, hardware updates, read capture
  always_comb
  begin
    stat_d   = stat_q;
    ctrl1_d  = ctrl1_q;
    ctrl3_d  = ctrl3_q;
    buf_d    = buf_q;
    own_d    = own_q;
    mask_d   = mask_q;
    irq_en_d = irq_en_q;
    irq_d    = irq_q;
    rdata_d  = rdata_q;
    // Hardware clears commands first so a same-cycle write re-arms them
    ctrl2_d = ctrl2_q;
    ctrl2_d[ssi_pkg::CTRL2_START] = ctrl2_q[ssi_pkg::CTRL2_START] & ~start_done;
    ctrl2_d[ssi_pkg::CTRL2_STOP]  = ctrl2_q[ssi_pkg::CTRL2_STOP] & ~stop_done & ~arb_ev;
    ctrl2_d[ssi_pkg::CTRL2_RCV]   = ctrl2_q[ssi_pkg::CTRL2_RCV] & ~rcv_done;
    if (wr_en)
      case (idx)
        ssi_pkg::IDX_STATUS:
        begin
          stat_d.slew  = i_pwdata[7];
          stat_d.smbus = i_pwdata[6];
        end
        ssi_pkg::IDX_CTRL1:    ctrl1_d  = i_pwdata[7:0];
        ssi_pkg::IDX_CTRL2:    ctrl2_d  = i_pwdata[7:0];
        ssi_pkg::IDX_CTRL3:    ctrl3_d  = i_pwdata[7:0];
        ssi_pkg::IDX_BUFFER:   buf_d    = i_pwdata[7:0];
        ssi_pkg::IDX_ADDR:
          if (mask_mode)
            mask_d = i_pwdata[7:0];
          else
            own_d = i_pwdata[7:0];
        ssi_pkg::IDX_IRQ_CLR:  irq_d    = irq_q & ~i_pwdata[ssi_pkg::IRQ_W-1:0];
        ssi_pkg::IDX_IRQ_EN:   irq_en_d = i_pwdata[ssi_pkg::IRQ_W-1:0];
        default:               rdata_d  = rdata_q;
      endcase
    // Acknowledge bit is hardware owned
    ctrl2_d[ssi_pkg::CTRL2_ACKST] = ack_q;
    // Reading the buffer empties it; a new byte in the same cycle wins
    if (rd_acc && idx == ssi_pkg::IDX_BUFFER)
      stat_d.buf_full = 1'b0;
    if (load_buf)
    begin
      buf_d           = shf_q;
      stat_d.buf_full = 1'b1;
    end
    if (byte_ev && slave_mode)
    begin
      stat_d.data_addr = is_data;
      stat_d.rd_wr     = is_data ? stat_q.rd_wr : shf_q[0];
    end
    if (start_det)
    begin
      stat_d.start = 1'b1;
      stat_d.stop  = 1'b0;
    end
    if (stop_det)
    begin
      stat_d.stop  = 1'b1;
      stat_d.start = 1'b0;
    end
    stat_d.upd_addr = 1'b0;
    // Sticky events; set beats a simultaneous clear
    irq_d[ssi_pkg::IRQ_BYTE] = irq_d[ssi_pkg::IRQ_BYTE] | byte_ev;
    irq_d[ssi_pkg::IRQ_STOP] = irq_d[ssi_pkg::IRQ_STOP] | stop_det;
    irq_d[ssi_pkg::IRQ_ARB]  = irq_d[ssi_pkg::IRQ_ARB] | arb_ev;
    // Read data captured in the setup cycle; the shifter has no slot
    if (setup)
      case (idx)
        ssi_pkg::IDX_STATUS:   rdata_d = {24'h000000, stat_q};
        ssi_pkg::IDX_CTRL1:    rdata_d = {24'h000000, ctrl1_q};
        ssi_pkg::IDX_CTRL2:    rdata_d = {24'h000000, ctrl2_q};
        ssi_pkg::IDX_CTRL3:    rdata_d = {24'h000000, ctrl3_q};
        ssi_pkg::IDX_BUFFER:   rdata_d = {24'h000000, buf_q};
        ssi_pkg::IDX_ADDR:     rdata_d = {24'h000000, mask_mode ? mask_q : own_q};
        ssi_pkg::IDX_IRQ_STAT: rdata_d = {29'h00000000, irq_q};
        ssi_pkg::IDX_IRQ_EN:   rdata_d = {29'h00000000, irq_en_q};
        default:               rdata_d = 32'h00000000;
      endcase
  end

  // Register file flops
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      stat_q   <= ssi_pkg::STAT_RESET;
      ctrl1_q  <= ssi_pkg::CTRL_RESET;
      ctrl2_q  <= ssi_pkg::CTRL_RESET;
      ctrl3_q  <= ssi_pkg::CTRL_RESET;
      buf_q    <= ssi_pkg::CTRL_RESET;
      own_q    <= ssi_pkg::ADDR_RESET;
      mask_q   <= ssi_pkg::MASK_RESET;
      irq_q    <= 3'h0;
      irq_en_q <= 3'h0;
      rdata_q  <= 32'h00000000;
    end
    else
    begin
      stat_q   <= stat_d;
      ctrl1_q  <= ctrl1_d;
      ctrl2_q  <= ctrl2_d;
      ctrl3_q  <= ctrl3_d;
      buf_q    <= buf_d;
      own_q    <= own_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
      irq_en_q <= irq_en_d;
      rdata_q  <= rdata_d;
    end
  end

  // Outputs; pins only ever pull low
  assign o_prdata        = rdata_q;
  assign o_pready        = 1'b1;
  assign o_pslverr       = i_psel & i_penable & ~hit;
  assign o_scl           = 1'b0;
  assign o_sda           = 1'b0;
  assign o_scl_oe_n      = ~scl_low_q;
  assign o_sda_oe_n      = ~sda_low_q;
  assign o_slew_ctrl_off = stat_q.slew;
  assign o_smbus_levels  = stat_q.smbus;
  assign o_irq           = |(irq_q & irq_en_q);

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_released;
    m_st_q == ssi_pkg::M_RISE && !scl_q;
  endsequence

  a_stat_reset_zero: assert property (@(posedge i_clk) disable iff (1'b0)
    i_srst |=> stat_q == ssi_pkg::STAT_RESET) else $error("status not zero after reset");
  a_rx_to_buffer: assert property (load_buf |=>
    buf_q == $past(shf_q) && stat_q.buf_full && irq_q[ssi_pkg::IRQ_BYTE])
    else $error("received byte not moved to buffer");
  a_tx_loads_both: assert property (buf_wr |=>
    buf_q == $past(i_pwdata[7:0]) && shf_q == $past(i_pwdata[7:0]))
    else $error("buffer write missed shifter");
  a_stop_last: assert property (stop_det |=> stat_q.stop && !stat_q.start)
    else $error("stop flag wrong");
  a_start_last: assert property (start_det |=> stat_q.start && !stat_q.stop)
    else $error("start flag wrong");
  a_stretch_wait: assert property (s_released |=> m_st_q == ssi_pkg::M_RISE && !scl_low_q)
    else $error("master ran past a held clock");
  a_arb_backoff: assert property (arb_ev |=> m_st_q == ssi_pkg::M_IDLE && o_sda_oe_n && o_scl_oe_n)
    else $error("lost arbitration but kept driving");
  a_msb_first: assert property (m_st_q == ssi_pkg::M_LOW && tick && tx_q &&
    cnt_q != ssi_pkg::SLOT_ACK |=> o_sda_oe_n == $past(shf_q[7]))
    else $error("bit order wrong");
  a_mask_shared: assert property (wr_en && idx == ssi_pkg::IDX_ADDR && mask_mode |=>
    mask_q == $past(i_pwdata[7:0]) && own_q == $past(own_q))
    else $error("mask write leaked into address");

endmodule

`default_nettype wire

// >>> ssi_pkg.sv
/*
  Constants and types shared by the two-wire serial port core.
  Assumes a 32-bit APB register bus; registers sit at word index times four.
*/
`default_nettype none

package ssi_pkg;

  // Register word indexes; the byte address is four times the index
  localparam logic [9:0] IDX_STATUS   = 10'h18F;  // serial_port_status
  localparam logic [9:0] IDX_CTRL1    = 10'h190;  // port_control_one
  localparam logic [9:0] IDX_CTRL2    = 10'h191;  // port_control_two
  localparam logic [9:0] IDX_CTRL3    = 10'h192;  // port_control_three
  localparam logic [9:0] IDX_BUFFER   = 10'h193;  // transfer_buffer
  localparam logic [9:0] IDX_ADDR     = 10'h194;  // own_address_or_rate_reload / mask
  localparam logic [9:0] IDX_IRQ_STAT = 10'h195;  // Sticky event flags, read only
  localparam logic [9:0] IDX_IRQ_CLR  = 10'h196;  // Write one to clear, write only
  localparam logic [9:0] IDX_IRQ_EN   = 10'h197;  // Event enables

  // port_control_one fields
  localparam int unsigned CTRL1_EN_BIT = 5;        // Port enable
  localparam logic [3:0]  MODE_SLAVE7  = 4'h6;     // Slave, 7-bit address
  localparam logic [3:0]  MODE_MASTER  = 4'h8;     // Master, rate from reload
  localparam logic [3:0]  MODE_MASK    = 4'h9;     // Slave, mask register reachable

  // port_control_two fields
  localparam int unsigned CTRL2_START  = 0;        // Issue start, self clearing
  localparam int unsigned CTRL2_STOP   = 2;        // Issue stop, self clearing
  localparam int unsigned CTRL2_RCV    = 3;        // Receive one byte, self clearing
  localparam int unsigned CTRL2_ACKDT  = 5;        // Acknowledge value sent as master
  localparam int unsigned CTRL2_ACKST  = 6;        // Acknowledge seen, hardware owned

  // Interrupt event bits
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_BYTE     = 0;        // port_irq_flag
  localparam int unsigned IRQ_STOP     = 1;
  localparam int unsigned IRQ_ARB      = 2;

  // Reset values
  localparam logic [7:0]  STAT_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  ADDR_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'hFF;

  // Bit slot counts within a byte frame
  localparam logic [3:0]  SLOT_ACK     = 4'h8;     // Eight data bits precede it
  localparam logic [3:0]  SLOT_END     = 4'h9;     // Ninth clock finished

  // serial_port_status layout, bit 7 first
  typedef struct packed {
    logic slew;       // sample_or_slew_select
    logic smbus;      // Bus-specific input levels
    logic data_addr;  // Last slave byte was data
    logic stop;       // Stop seen last
    logic start;      // Start seen last
    logic rd_wr;      // Direction of last address
    logic upd_addr;   // Unused, reads zero
    logic buf_full;   // transfer_buffer holds unread data
  } ssi_stat_type;

  // Master sequencer
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_HOLD, M_LOW, M_REL, M_RISE, M_HIGH, M_STOP, M_STOPW
  } ssi_mst_type;

  // Slave sequencer
  typedef enum logic [1:0] {
    S_IDLE, S_ADDR, S_RX, S_TX
  } ssi_slv_type;

endpackage

`default_nettype wire

// >>> ssi_slave_model.sv
/*
  Behavioural two-wire slave on the far side of the port: takes one byte,
  acknowledges it and stretches the clock after every falling edge.
  Assumes wired-AND lines with pull-ups resolved by the testbench.
*/
`timescale 1ns/1ns
`default_nettype none

module ssi_slave_model (
  // Resolved bus levels
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  // Pull-down requests and captured byte
  output var  logic       o_scl_low,
  output var  logic       o_sda_low,
  output var  logic [7:0] o_byte
);
  int cnt = 0;  // Clocks seen in this frame

  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_byte    = 8'h00;
  end

  // Start condition restarts the frame
  always @(negedge i_sda)
  begin
    if (i_scl)
      cnt = 0;
  end

  // Data bits shift in on the rising clock, first bit is the top bit
  always @(posedge i_scl)
  begin
    if (cnt < 8)
      o_byte = {o_byte[6:0], i_sda};
    cnt = cnt + 1;
  end

  // Hold the clock low a while, a slow slave; acknowledge after 8 bits
  always @(negedge i_scl)
  begin
    o_scl_low = 1'b1;
    o_sda_low = (cnt == 8);
    #40;
    o_scl_low = 1'b0;
  end
endmodule

`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the two-wire port: APB register tasks, a master
  transfer to a stretching slave model, status and interrupt checks.
  Assumes the port answers APB with pready high in the access cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic        i_clk, i_srst, psel, pen, pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        pready, pslverr, scl_oe_n, sda_oe_n, slew, smb, irq;
  logic        m_scl, m_sda;
  logic [7:0]  mbyte;
  logic        rival_sda;  // A second master pulling the data line low
  logic        rerr;       // Slave error sampled with the answer
  wire logic   scl = scl_oe_n & ~m_scl;  // Pull-ups: released lines go high
  wire logic   sda = sda_oe_n & ~m_sda & ~rival_sda;
  int          error_cnt = 0;
  int          compares = 0;

  ssi_core dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .o_scl(),
    .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(), .o_sda_oe_n(sda_oe_n),
    .o_slew_ctrl_off(slew), .o_smbus_levels(smb), .o_irq(irq));
  ssi_slave_model peer (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl),
    .o_sda_low(m_sda), .o_byte(mbyte));

  // 250 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready, holds the request until then
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1; pwr <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge i_clk);
    end
    if (pready !== 1'b1)
      error_cnt++;  // Answer never came
    rv   = prdata;
    rerr = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("register", rv, exp);
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog against a hung transfer
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    i_srst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    rival_sda = 1'b0;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd(ssi_pkg::IDX_STATUS, 32'h00);
    rd(ssi_pkg::IDX_ADDR, 32'h00);
    apb(1'b1, 10'h3FF, 8'h55);
    chk("slave error", rerr, 1'b1);
    apb(1'b1, ssi_pkg::IDX_STATUS, 8'hFF);
    rd(ssi_pkg::IDX_STATUS, 32'hC0);
    chk("slew off", slew, 1'b1);
    chk("bus levels", smb, 1'b1);
    apb(1'b1, ssi_pkg::IDX_CTRL3, 8'h5A);
    rd(ssi_pkg::IDX_CTRL3, 32'h5A);
    // Mask shares the address slot only in mask mode
    apb(1'b1, ssi_pkg::IDX_CTRL1, 8'h29);
    rd(ssi_pkg::IDX_ADDR, 32'hFF);
    apb(1'b1, ssi_pkg::IDX_ADDR, 8'hF0);
    apb(1'b1, ssi_pkg::IDX_CTRL1, 8'h28);
    rd(ssi_pkg::IDX_ADDR, 32'h00);
    // Master send of one byte with reload 2
    apb(1'b1, ssi_pkg::IDX_ADDR, 8'h02);
    apb(1'b1, ssi_pkg::IDX_IRQ_EN, 8'h01);
    apb(1'b1, ssi_pkg::IDX_CTRL2, 8'h01);
    repeat (40) @(posedge i_clk);
    apb(1'b1, ssi_pkg::IDX_BUFFER, 8'hA5);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge i_clk);
    chk("irq", irq, 1'b1);
    chk("byte on wire", mbyte, 8'hA5);
    rd(ssi_pkg::IDX_BUFFER, 32'hA5);
    apb(1'b0, ssi_pkg::IDX_STATUS, 8'h00);
    chk("start seen", rv & 32'h18, 32'h08);
    apb(1'b1, ssi_pkg::IDX_IRQ_CLR, 8'h01);
    @(posedge i_clk);
    chk("irq cleared", irq, 1'b0);
    // Master receive of one byte from an idle line, acked by us
    apb(1'b1, ssi_pkg::IDX_CTRL2, 8'h08);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge i_clk);
    chk("rx irq", irq, 1'b1);
    apb(1'b0, ssi_pkg::IDX_STATUS, 8'h00);
    chk("buffer full", rv & 32'h01, 32'h01);
    rd(ssi_pkg::IDX_BUFFER, 32'hFF);
    apb(1'b0, ssi_pkg::IDX_STATUS, 8'h00);
    chk("buffer read", rv & 32'h11, 32'h00);
    apb(1'b1, ssi_pkg::IDX_CTRL2, 8'h04);
    for (int i = 0; i < 100 && (rv & 32'h10) == 0; i++)
      apb(1'b0, ssi_pkg::IDX_STATUS, 8'h00);
    chk("stop seen", rv & 32'h18, 32'h10);
    // A rival master holds the data line low while we send ones
    apb(1'b1, ssi_pkg::IDX_IRQ_CLR, 8'h07);
    apb(1'b1, ssi_pkg::IDX_IRQ_EN, 8'h04);
    apb(1'b1, ssi_pkg::IDX_CTRL2, 8'h01);
    repeat (40) @(posedge i_clk);
    rival_sda <= 1'b1;
    apb(1'b1, ssi_pkg::IDX_BUFFER, 8'hFF);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge i_clk);
    chk("lines freed", {scl_oe_n, sda_oe_n}, 2'b11);
    rd(ssi_pkg::IDX_IRQ_STAT, 32'h04);
    rival_sda <= 1'b0;
    close_out();
  end
endmodule

`default_nettype wire
